// ===== logic/arf_accum.sv
// result accumulate and format stage of the converter
`timescale 1ns/1ps
`default_nettype none

module arf_accum
    import arf_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic conv_start,
    input wire arf_cfg_type cfg,
    input wire arf_sample_type sample,
    output logic [`ARF_RES_W-1:0] conversion_result_register_q,
    output logic result_ready_q,
    output logic busy_q,
    output logic clipped_q
);

    ////////////////////////////////////////////////////////////////////////
    // state

    arf_regs_type q;
    arf_regs_type d;

    logic [`ARF_CODE_W-1:0] sat_code;
    logic [`ARF_ACC_W-1:0] ext_code;
    logic [`ARF_ACC_W-1:0] sum;
    logic [`ARF_CNT_W-1:0] target;
    logic [`ARF_CNT_W-1:0] cnt_next;
    logic [`ARF_ACC_W-1:0] shifted;
    logic [`ARF_RES_W-1:0] formatted;
    logic [2:0] right_shift;
    logic [2:0] left_shift;
    logic sample_clip;

    ////////////////////////////////////////////////////////////////////////
    // saturation and sign handling of one code

    always_comb begin
        sat_code = sample.code;
        sample_clip = sample.over_range | sample.under_range;
        // over range wins if the core ever flags both
        if (sample.over_range) begin
            if (q.cfg.differential) begin
                sat_code = `ARF_DIFF_MAX;
            end else begin
                sat_code = `ARF_SE_MAX;
            end
        end else if (sample.under_range) begin
            if (q.cfg.differential) begin
                sat_code = `ARF_DIFF_MIN;
            end else begin
                sat_code = `ARF_SE_MIN;
            end
        end
        if (q.cfg.differential) begin
            ext_code = {{`ARF_EXT_W{sat_code[`ARF_CODE_W-1]}}, sat_code};
        end else begin
            ext_code = {{`ARF_EXT_W{1'b0}}, sat_code};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // running sum and sample count

    always_comb begin
        // 19 bits hold 128 full-scale codes of either sign
        sum = q.acc + ext_code;
        cnt_next = q.cnt + `ARF_CNT_ONE;
        target = `ARF_CNT_ONE << q.cfg.sample_count_select;
    end

    ////////////////////////////////////////////////////////////////////////
    // result placement

    always_comb begin
        right_shift = 3'h0;
        left_shift = 3'h0;
        if (q.cfg.sample_count_select > `ARF_FULL_LOG2) begin
            right_shift = q.cfg.sample_count_select - `ARF_FULL_LOG2;
        end else begin
            left_shift = `ARF_FULL_LOG2 - q.cfg.sample_count_select;
        end
        // arithmetic shift keeps the sign of differential sums
        shifted = $unsigned($signed(q.acc) >>> right_shift);
        if (q.cfg.sample_count_select >= `ARF_FULL_LOG2) begin
            // adjust has no effect once the sum fills the word
            formatted = shifted[`ARF_RES_W-1:0];
        end else if (q.cfg.left_adjust_select) begin
            // low bits vacated by the shift read as zero
            formatted = q.acc[`ARF_RES_W-1:0] << left_shift;
        end else begin
            // upper bits of acc already hold zeros or the sign
            formatted = q.acc[`ARF_RES_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        d = q;
        d.ready = 1'b0;
        unique case (q.st)
            ARF_IDLE: begin
                d.busy = 1'b0;
            end
            ARF_ACCUM: begin
                if (sample.valid) begin
                    d.acc = sum;
                    d.cnt = cnt_next;
                    d.clip_acc = q.clip_acc | sample_clip;
                    if (cnt_next == target) begin
                        d.st = ARF_FORMAT;
                    end
                end
            end
            ARF_FORMAT: begin
                // result only moves once every sample is in
                d.result = formatted;
                d.clipped = q.clip_acc;
                d.ready = 1'b1;
                d.busy = 1'b0;
                d.st = ARF_IDLE;
            end
        endcase
        // a start always restarts, even mid accumulation
        if (conv_start) begin
            d.st = ARF_ACCUM;
            d.cfg = cfg;
            d.acc = `ARF_ACC_RESET;
            d.cnt = `ARF_CNT_RESET;
            d.clip_acc = 1'b0;
            d.busy = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            q.st <= ARF_IDLE;
            q.cfg <= '0;
            q.acc <= `ARF_ACC_RESET;
            q.cnt <= `ARF_CNT_RESET;
            q.result <= `ARF_RES_RESET;
            q.ready <= 1'b0;
            q.busy <= 1'b0;
            q.clipped <= 1'b0;
            q.clip_acc <= 1'b0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign conversion_result_register_q = q.result;
    assign result_ready_q = q.ready;
    assign busy_q = q.busy;
    assign clipped_q = q.clipped;

endmodule : arf_accum

`default_nettype wire

// ===== pkg/arf_defs.svh
// constants of the result accumulate and format stage
`ifndef ARF_DEFS_SVH
`define ARF_DEFS_SVH

`define ARF_CODE_W 12
`define ARF_ACC_W 19
`define ARF_RES_W 16
`define ARF_CNT_W 8
`define ARF_EXT_W 7
`define ARF_SE_MAX 12'hfff
`define ARF_SE_MIN 12'h000
`define ARF_DIFF_MAX 12'h7ff
`define ARF_DIFF_MIN 12'h800
`define ARF_RES_RESET 16'h0000
`define ARF_ACC_RESET 19'h00000
`define ARF_CNT_RESET 8'h00
`define ARF_CNT_ONE 8'h01
`define ARF_FULL_LOG2 3'h4

`endif

// ===== pkg/arf_pkg.sv
// types of the result accumulate and format stage
`include "arf_defs.svh"

package arf_pkg;

    // one conversion code from the converter core
    typedef struct packed {
        logic valid;
        logic over_range;
        logic under_range;
        logic [`ARF_CODE_W-1:0] code;
    } arf_sample_type;

    // format settings, latched at conversion start
    typedef struct packed {
        logic left_adjust_select;
        logic differential;
        logic [2:0] sample_count_select;
    } arf_cfg_type;

    typedef enum logic [2:0] {
        ARF_IDLE = 3'b001,
        ARF_ACCUM = 3'b010,
        ARF_FORMAT = 3'b100
    } arf_state_type;

    typedef struct packed {
        arf_state_type st;
        arf_cfg_type cfg;
        logic [`ARF_ACC_W-1:0] acc;
        logic [`ARF_CNT_W-1:0] cnt;
        logic [`ARF_RES_W-1:0] result;
        logic ready;
        logic busy;
        logic clipped;
        logic clip_acc;
    } arf_regs_type;

endpackage : arf_pkg

// ===== tb/arf_accum_chk.sv
// assertion checker of the accumulate and format stage
`timescale 1ns/1ps
`default_nettype none
module arf_accum_chk
    import arf_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic conv_start,
    input wire arf_cfg_type cfg,
    input wire arf_sample_type sample,
    input wire logic [15:0] conversion_result_register_q,
    input wire logic result_ready_q,
    input wire logic busy_q,
    input wire logic clipped_q
);
    arf_cfg_type cfg_q;
    logic [15:0] res;
    logic [2:0] sel;
    assign res = conversion_result_register_q;
    assign sel = cfg_q.sample_count_select;
    // settings only count at start, so mirror that latch
    always_ff @(posedge core_clk) begin
        if (conv_start) begin
            cfg_q <= cfg;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_ready_one_pulse: assert property (result_ready_q |=> !result_ready_q)
        else $error("ready too long");
    a_result_holds: assert property (!result_ready_q |-> $stable(res))
        else $error("result moved");
    a_busy_on_start: assert property (conv_start |=> busy_q)
        else $error("no busy");
    a_ready_ends_busy: assert property (result_ready_q |-> !busy_q)
        else $error("busy at ready");
    a_ready_after_last: assert property (result_ready_q |-> $past(sample.valid, 2))
        else $error("ready timing");
    a_clip_seen: assert property (result_ready_q && $past(sample.valid &&
        (sample.over_range || sample.under_range), 2) |-> clipped_q)
        else $error("clip lost");
    a_left_low_zero: assert property (result_ready_q && cfg_q.left_adjust_select
        && sel < 3'h4 |-> (res & ((16'h0010 >> sel) - 16'h0001)) == 16'h0000)
        else $error("left low bits");
    a_right_high_zero: assert property (result_ready_q && !cfg_q.left_adjust_select
        && !cfg_q.differential && sel < 3'h4 |-> (res >> (12 + sel)) == 16'h0000)
        else $error("right high bits");
endmodule : arf_accum_chk
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench of the accumulate and format stage
`timescale 1ns/1ps
`default_nettype none
module tb;
    import arf_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic conv_start = 1'b0;
    arf_cfg_type cfg = '0;
    arf_sample_type sample = '0;
    logic [15:0] res;
    logic rdy;
    logic busy;
    logic clip;
    int fails = 0;
    int cmp_count = 0;
    arf_accum u_dut (.core_clk(core_clk), .resetn(resetn), .conv_start(conv_start), .cfg(cfg),
        .sample(sample), .conversion_result_register_q(res), .result_ready_q(rdy),
        .busy_q(busy), .clipped_q(clip));
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic wrap_up();
        $display("compares %0d fails %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up
    // n equal codes; the start cycle carries no code since it would be ignored
    task automatic conv(input string nm, input arf_cfg_type c, input int n,
        input logic [11:0] cd, input logic [1:0] ou, input logic [15:0] e);
        int k;
        cfg = c;
        conv_start = 1'b1;
        @(posedge core_clk) #1;
        conv_start = 1'b0;
        chk("busy", 16'h0001, {15'h0, busy});
        for (k = 0; k < n; k++) begin
            sample = {1'b1, ou, cd};
            @(posedge core_clk) #1;
        end
        sample = '0;
        k = 0;
        while (rdy !== 1'b1 && k < 8) begin
            @(posedge core_clk) #1;
            k++;
        end
        // loop starts one edge after the last code, so the format edge counts once
        chk("latency", 16'h0001, 16'(k));
        chk(nm, e, res);
        chk("clipped", {15'h0, ou != 2'b00}, {15'h0, clip});
        $display("test %s done", nm);
    endtask : conv
    task automatic t_abort();
        cfg = 5'b00001;
        conv_start = 1'b1;
        @(posedge core_clk) #1;
        conv_start = 1'b0;
        sample = {1'b1, 2'b00, 12'h7ff};
        @(posedge core_clk) #1;
        sample = '0;
        conv("restart", 5'b00000, 1, 12'h005, 2'b00, 16'h0005);
    endtask : t_abort
    initial begin
        repeat (4) @(posedge core_clk);
        #1 resetn = 1'b1;
        chk("reset", 16'h0000, res);
        conv("sum2", 5'b00001, 2, 12'h180, 2'b00, 16'h0300);
        conv("left1", 5'b10000, 1, 12'habc, 2'b00, 16'habc0);
        conv("left4", 5'b10010, 4, 12'h001, 2'b00, 16'h0010);
        conv("se_hi", 5'b00000, 1, 12'h123, 2'b10, 16'h0fff);
        conv("se_lo", 5'b00000, 1, 12'h123, 2'b01, 16'h0000);
        conv("df_hi", 5'b01000, 1, 12'h123, 2'b10, 16'h07ff);
        conv("df_lo", 5'b01000, 1, 12'h123, 2'b01, 16'hf800);
        conv("df2", 5'b01001, 2, 12'hfff, 2'b00, 16'hfffe);
        conv("df2l", 5'b11001, 2, 12'hfff, 2'b00, 16'hfff0);
        conv("se32", 5'b00101, 32, 12'hfff, 2'b00, 16'hfff0);
        conv("se16l", 5'b10100, 16, 12'h001, 2'b00, 16'h0010);
        conv("se8", 5'b00011, 8, 12'hfff, 2'b00, 16'h7ff8);
        conv("se8l", 5'b10011, 8, 12'hfff, 2'b00, 16'hfff0);
        conv("df128", 5'b01111, 128, 12'h7ff, 2'b00, 16'h7ff0);
        conv("df64", 5'b11110, 64, 12'h800, 2'b00, 16'h8000);
        t_abort();
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        fails++;
        wrap_up();
    end
endmodule : tb
bind arf_accum arf_accum_chk u_chk (.core_clk(core_clk), .resetn(resetn),
    .conv_start(conv_start), .cfg(cfg), .sample(sample), .busy_q(busy_q), .clipped_q(clipped_q),
    .conversion_result_register_q(conversion_result_register_q), .result_ready_q(result_ready_q));
`default_nettype wire
